// *** hdl/vtoh_pkg.sv ***
// constants for the tributary overhead control/status register bank
// assumes one 20 MHz clock and a synchronous byte-wide cpu port
package vtoh_pkg;
  localparam logic [7:0] ADDR_TX_CTRL = 8'h2d;
  localparam logic [7:0] ADDR_TX_OBITS = 8'h2e;
  localparam logic [7:0] ADDR_DROP_SEL = 8'h2f;
  localparam logic [7:0] ADDR_PAR_CNT = 8'h30;
  localparam logic [7:0] ADDR_FAR_CNT = 8'h31;
  localparam logic [7:0] ADDR_LBL_ALM = 8'h32;
  localparam logic [7:0] ADDR_PTR_ALM = 8'h33;
  localparam logic [7:0] ADDR_EXP_LBL = 8'h36;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] EXP_RESET = 3'h0;
  // tx control and drop select bit positions
  localparam int CTL_AIS = 7;
  localparam int CTL_PINV = 6;
  localparam int CTL_FINV = 5;
  localparam int CTL_RDI = 4;
  localparam int CTL_RFI = 3;
  localparam int SEL_SIDE = 7;
  // alarm bit positions
  localparam int ALM_UNEQ = 7;
  localparam int ALM_SLER = 6;
  localparam int ALM_NDF = 3;
  localparam int ALM_FIFO = 0;
  localparam int ALM_AIS = 7;
  localparam int ALM_LOP = 6;
  localparam int ALM_SIZE = 5;
  // byte bit n (1 = msb) sits at index 8-n
  localparam int V5_FEBE = 5;
  localparam int V5_RFI = 4;
  localparam int V5_RDI = 0;
  localparam logic [3:0] NDF_CODE = 4'h9;
  localparam logic [1:0] SIZE_CODE = 2'h3;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [6:0] TRIB_MAX = 7'h54;
  localparam logic [6:0] VT_PER_STS = 7'h1c;
  localparam logic [6:0] VT_PER_GRP = 7'h04;
  localparam logic [3:0] AIS_FRAMES = 4'h3;
  localparam logic [3:0] LOP_FRAMES = 4'h8;
  typedef struct packed {
    logic valid;
    logic [1:0] sts;
    logic [2:0] grp;
    logic [1:0] vt;
  } vtoh_trib_t;
endpackage : vtoh_pkg

// *** hdl/vtoh_ptr_if.sv ***
// pointer interpreter hand-off between register bank and monitor
// assumes per-frame strobes from the drop-side pointer tracker
`timescale 1ns/1ns
interface vtoh_ptr_if;
  logic frame;
  logic ptr_ais;
  logic ptr_bad;
  logic ais_state;
  logic lop_state;
  modport mon (input frame, ptr_ais, ptr_bad, output ais_state, lop_state);
  modport user (output frame, ptr_ais, ptr_bad, input ais_state, lop_state);
endinterface : vtoh_ptr_if

// *** hdl/vtoh_ptr_mon.sv ***
// consecutive-frame pointer state tracker (ais and loss of pointer)
// assumes frame is a one-cycle strobe once per received pointer
`timescale 1ns/1ns
module vtoh_ptr_mon
  import vtoh_pkg::*;
(
  input logic clk,
  input logic rst_n,
  vtoh_ptr_if.mon ptr
);
  logic [3:0] ais_cnt_reg;
  logic [3:0] ais_cnt_next;
  logic [3:0] lop_cnt_reg;
  logic [3:0] lop_cnt_next;
  wire ais_full = (ais_cnt_reg == AIS_FRAMES);
  wire lop_full = (lop_cnt_reg == LOP_FRAMES);
  wire bad_frame = ptr.ptr_bad & ~ptr.ptr_ais;

  // any good frame breaks the run
  assign ais_cnt_next = !ptr.frame ? ais_cnt_reg :
    !ptr.ptr_ais ? 4'h0 :
    ais_full ? ais_cnt_reg : ais_cnt_reg + 4'h1; // [RULE24]
  assign lop_cnt_next = !ptr.frame ? lop_cnt_reg :
    !bad_frame ? 4'h0 :
    lop_full ? lop_cnt_reg : lop_cnt_reg + 4'h1; // [RULE24]
  assign ptr.ais_state = ais_full;
  assign ptr.lop_state = lop_full;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ais_cnt_reg <= 4'h0;
      lop_cnt_reg <= 4'h0;
    end else begin
      ais_cnt_reg <= ais_cnt_next;
      lop_cnt_reg <= lop_cnt_next;
    end
  end

  property p_lop_enter;
    @(posedge clk) disable iff (!rst_n)
    (lop_cnt_reg == LOP_FRAMES - 4'h1) && ptr.frame && bad_frame
      |=> ptr.lop_state;
  endproperty
  a_lop_enter: assert property (p_lop_enter) // [RULE24]
    else $error("loss of pointer not declared");

  property p_ais_leave;
    @(posedge clk) disable iff (!rst_n)
    ptr.frame && !ptr.ptr_ais |=> !ptr.ais_state;
  endproperty
  a_ais_leave: assert property (p_ais_leave) // [RULE24]
    else $error("ais state kept after good frame");
endmodule : vtoh_ptr_mon

// *** hdl/vtoh_regs.sv ***
// tributary overhead control/status register bank, one port
// assumes synchronous cpu strobes and one-cycle datapath strobes
`timescale 1ns/1ns
// Contract
// (RULE1) tx ais forces whole tributary to ones
// (RULE2) force parity inverts v5 bits 1-2
// (RULE3) force far error inverts v5 bit 3
// (RULE4) remote defect sets v5 bit 8
// (RULE5) remote failure sets v5 bit 4
// (RULE6) tx label goes to v5 bits 5-7
// (RULE7) comm bits go into justification bytes
// (RULE8) side select bit: one picks b bus
// (RULE9) zero or out-of-range number gives ais
// (RULE10) numbers 1, 29, 57 pick sts 1-3
// (RULE11) output enable low tristates, overrides ais
// (RULE12) parity errors: 8-bit saturating, two/frame
// (RULE13) errors held during read, added after
// (RULE14) counters clear on reset, command, read
// (RULE15) far error bit counted, 8-bit saturating
// (RULE16) all-zero label latches unequipped
// (RULE17) label differing from expected latches mismatch
// (RULE18) v1 bits 1-4 of 1001 latch ndf
// (RULE19) add fifo error latches, fifo auto-resets
// (RULE20) ais and loss of pointer latch
// (RULE21) v1 size bits not 11 latch error
// (RULE22) alarms clear on read, relatch if active
// (RULE23) software writes the expected label
// (RULE24) pointer states need consecutive bad frames
module vtoh_regs
  import vtoh_pkg::*;
(
  input logic clk,
  input logic rst_n,
  input logic [7:0] cpu_addr,
  input logic [7:0] cpu_data_in,
  output logic [7:0] cpu_data_out,
  output logic cpu_data_oe,
  input logic cpu_cs_n,
  input logic cpu_rd_n,
  input logic cpu_wr_n,
  input logic port_output_enable,
  input logic counter_reset,
  input logic [7:0] tx_byte_in,
  input logic tx_v5_slot,
  input logic tx_obit1_slot,
  input logic tx_obit2_slot,
  input logic [1:0] tx_bip2_calc,
  input logic tx_febe_calc,
  output logic [7:0] tx_byte_out,
  output logic drop_bus_b_sel,
  output logic trib_sel_valid,
  output logic [1:0] trib_sts,
  output logic [2:0] trib_grp,
  output logic [1:0] trib_vt,
  output logic drop_ais_gen,
  output logic line_out_oe,
  input logic rx_v5_strobe,
  input logic [7:0] rx_v5_byte,
  input logic [1:0] rx_bip2_errs,
  input logic rx_v1_strobe,
  input logic [7:0] rx_v1_byte,
  input logic rx_ptr_frame,
  input logic rx_ptr_ais,
  input logic rx_ptr_bad,
  input logic add_fifo_ovf,
  input logic add_fifo_udf,
  output logic add_fifo_reset
);
  function automatic vtoh_trib_t trib_decode(input logic [6:0] n);
    vtoh_trib_t t;
    logic [6:0] m;
    logic [6:0] r;
    m = n - 7'h01;
    r = m % VT_PER_STS;
    t.valid = (n != 7'h00) && (n <= TRIB_MAX);
    t.sts = 2'(m / VT_PER_STS);
    t.grp = 3'(r / VT_PER_GRP);
    t.vt = 2'(r % VT_PER_GRP);
    return t;
  endfunction : trib_decode

  logic [7:0] ctrl_reg;
  logic [7:0] obits_reg;
  logic [7:0] sel_reg;
  logic [2:0] exp_reg;
  logic [7:0] lbl_alm_reg;
  logic [7:0] lbl_alm_next;
  logic [7:0] ptr_alm_reg;
  logic [7:0] ptr_alm_next;
  logic [2:0] rx_label_reg;
  logic label_seen_reg;
  logic rd_reg;
  logic wr_reg;
  logic [7:0] rd_addr_reg;
  logic [7:0] rd_mux;
  logic [7:0] tx_next;
  logic [7:0] v5_build;
  logic [7:0] cnt_reg [2];
  logic [7:0] pend_reg [2];
  logic [1:0] cnt_inc [2];
  vtoh_trib_t trib_dec;

  vtoh_ptr_if ptr_bus ();
  assign ptr_bus.frame = rx_ptr_frame;
  assign ptr_bus.ptr_ais = rx_ptr_ais;
  assign ptr_bus.ptr_bad = rx_ptr_bad;

  vtoh_ptr_mon u_ptr_mon (
    .clk(clk),
    .rst_n(rst_n),
    .ptr(ptr_bus)
  );

  // cpu strobes
  wire rd_now = ~cpu_cs_n & ~cpu_rd_n;
  wire wr_now = ~cpu_cs_n & ~cpu_wr_n;
  wire rd_start = rd_now & ~rd_reg;
  wire rd_done = rd_reg & ~rd_now;
  wire wr_start = wr_now & ~wr_reg;
  wire wr_ctrl = wr_start && (cpu_addr == ADDR_TX_CTRL);
  wire wr_obits = wr_start && (cpu_addr == ADDR_TX_OBITS);
  wire wr_sel = wr_start && (cpu_addr == ADDR_DROP_SEL);
  wire wr_exp = wr_start && (cpu_addr == ADDR_EXP_LBL);
  wire done_lbl = rd_done && (rd_addr_reg == ADDR_LBL_ALM);
  wire done_ptr = rd_done && (rd_addr_reg == ADDR_PTR_ALM);

  always_comb begin
    if (cpu_addr == ADDR_TX_CTRL) begin
      rd_mux = ctrl_reg;
    end else if (cpu_addr == ADDR_TX_OBITS) begin
      rd_mux = obits_reg;
    end else if (cpu_addr == ADDR_DROP_SEL) begin
      rd_mux = sel_reg;
    end else if (cpu_addr == ADDR_PAR_CNT) begin
      rd_mux = cnt_reg[0];
    end else if (cpu_addr == ADDR_FAR_CNT) begin
      rd_mux = cnt_reg[1];
    end else if (cpu_addr == ADDR_LBL_ALM) begin
      rd_mux = lbl_alm_reg;
    end else if (cpu_addr == ADDR_PTR_ALM) begin
      rd_mux = ptr_alm_reg;
    end else if (cpu_addr == ADDR_EXP_LBL) begin
      rd_mux = {5'h00, exp_reg};
    end else begin
      rd_mux = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
      cpu_data_out <= 8'h00;
      cpu_data_oe <= 1'b0;
    end else begin
      rd_reg <= rd_now;
      wr_reg <= wr_now;
      cpu_data_oe <= rd_now;
      // snapshot at read start; also the mask of bits to clear
      if (rd_start) begin
        rd_addr_reg <= cpu_addr;
        cpu_data_out <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= REG_RESET;
      obits_reg <= REG_RESET;
      sel_reg <= REG_RESET;
      exp_reg <= EXP_RESET;
    end else begin
      if (wr_ctrl) ctrl_reg <= cpu_data_in;
      if (wr_obits) obits_reg <= cpu_data_in;
      if (wr_sel) sel_reg <= cpu_data_in;
      if (wr_exp) exp_reg <= cpu_data_in[2:0]; // [RULE23]
    end
  end

  // transmit byte insertion
  assign v5_build = {
    tx_bip2_calc ^ {2{ctrl_reg[CTL_PINV]}},           // [RULE2]
    tx_febe_calc ^ ctrl_reg[CTL_FINV],                // [RULE3]
    ctrl_reg[CTL_RFI],                                // [RULE5]
    ctrl_reg[0], ctrl_reg[1], ctrl_reg[2],            // [RULE6]
    ctrl_reg[CTL_RDI]                                 // [RULE4]
  };

  always_comb begin
    if (ctrl_reg[CTL_AIS]) begin
      tx_next = ALL_ONES; // [RULE1]
    end else if (tx_v5_slot) begin
      tx_next = v5_build;
    end else if (tx_obit1_slot) begin
      tx_next = {tx_byte_in[7:6], obits_reg[3:0], tx_byte_in[1:0]}; // [RULE7]
    end else if (tx_obit2_slot) begin
      tx_next = {tx_byte_in[7:6], obits_reg[7:4], tx_byte_in[1:0]}; // [RULE7]
    end else begin
      tx_next = tx_byte_in;
    end
  end

  assign trib_dec = trib_decode(sel_reg[6:0]); // [RULE10]
  assign drop_bus_b_sel = sel_reg[SEL_SIDE]; // [RULE8]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_byte_out <= 8'h00;
      trib_sel_valid <= 1'b0;
      trib_sts <= 2'h0;
      trib_grp <= 3'h0;
      trib_vt <= 2'h0;
      drop_ais_gen <= 1'b0;
      line_out_oe <= 1'b0;
      add_fifo_reset <= 1'b0;
    end else begin
      tx_byte_out <= tx_next;
      trib_sel_valid <= trib_dec.valid;
      trib_sts <= trib_dec.sts;
      trib_grp <= trib_dec.grp;
      trib_vt <= trib_dec.vt;
      // disabled outputs win over generated ais
      drop_ais_gen <= ~trib_dec.valid & port_output_enable; // [RULE9] [RULE11]
      line_out_oe <= port_output_enable; // [RULE11]
      add_fifo_reset <= add_fifo_ovf | add_fifo_udf; // [RULE19]
    end
  end

  // error counters: 0 = parity, 1 = far end
  assign cnt_inc[0] = rx_v5_strobe ? rx_bip2_errs : 2'h0; // [RULE12]
  assign cnt_inc[1] = {1'b0, rx_v5_strobe & rx_v5_byte[V5_FEBE]}; // [RULE15]

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cnt
      localparam logic [7:0] CADDR = gi == 0 ? ADDR_PAR_CNT : ADDR_FAR_CNT;
      wire reading = rd_now && (cpu_addr == CADDR);
      wire done = rd_done && (rd_addr_reg == CADDR);
      wire [7:0] base = (counter_reset | done) ? 8'h00 : cnt_reg[gi];
      wire [1:0] live = reading ? 2'h0 : cnt_inc[gi];
      wire [7:0] held = done ? pend_reg[gi] : 8'h00;
      wire [9:0] sum = {2'h0, base} + {8'h00, live} + {2'h0, held};
      wire [8:0] psum = {1'b0, pend_reg[gi]} + {7'h00, cnt_inc[gi]};
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          cnt_reg[gi] <= 8'h00; // [RULE14]
          pend_reg[gi] <= 8'h00;
        end else begin
          // saturate rather than wrap
          cnt_reg[gi] <= (sum > {2'h0, CNT_MAX}) ? CNT_MAX : sum[7:0];
          if (reading) begin
            pend_reg[gi] <= psum[8] ? CNT_MAX : psum[7:0]; // [RULE13]
          end else begin
            pend_reg[gi] <= 8'h00;
          end
        end
      end
    end
  endgenerate

  // latched alarms
  wire [2:0] rx_label = {rx_v5_byte[1], rx_v5_byte[2], rx_v5_byte[3]};
  wire uneq_set = label_seen_reg && (rx_label_reg == 3'h0); // [RULE16]
  wire sler_set = label_seen_reg && (rx_label_reg != exp_reg); // [RULE17]
  wire ndf_set = rx_v1_strobe && (rx_v1_byte[7:4] == NDF_CODE); // [RULE18]
  wire size_set = rx_v1_strobe && (rx_v1_byte[3:2] != SIZE_CODE); // [RULE21]
  wire fifo_set = add_fifo_ovf | add_fifo_udf; // [RULE19]
  wire [7:0] lbl_set = {uneq_set, sler_set, 2'h0, ndf_set, 2'h0, fifo_set};
  wire [7:0] ptr_set = {ptr_bus.ais_state, ptr_bus.lop_state, size_set,
    5'h00}; // [RULE20]
  // only bits that were reported are cleared; a new set wins
  assign lbl_alm_next = (lbl_alm_reg & ~(done_lbl ? cpu_data_out : 8'h00))
    | lbl_set; // [RULE22]
  assign ptr_alm_next = (ptr_alm_reg & ~(done_ptr ? cpu_data_out : 8'h00))
    | ptr_set; // [RULE22]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lbl_alm_reg <= 8'h00;
      ptr_alm_reg <= 8'h00;
      rx_label_reg <= 3'h0;
      label_seen_reg <= 1'b0;
    end else begin
      lbl_alm_reg <= lbl_alm_next;
      ptr_alm_reg <= ptr_alm_next;
      if (rx_v5_strobe) begin
        rx_label_reg <= rx_label;
        label_seen_reg <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_ais_ones;
    ctrl_reg[CTL_AIS] |=> tx_byte_out == ALL_ONES;
  endproperty
  a_ais_ones: assert property (p_ais_ones) // [RULE1]
    else $error("tributary ais not all ones");

  property p_par_inv;
    tx_v5_slot && !ctrl_reg[CTL_AIS] && ctrl_reg[CTL_PINV]
      |=> tx_byte_out[7:6] == ~$past(tx_bip2_calc);
  endproperty
  a_par_inv: assert property (p_par_inv) // [RULE2]
    else $error("v5 parity not inverted");

  property p_far_inv;
    tx_v5_slot && !ctrl_reg[CTL_AIS]
      |=> tx_byte_out[V5_FEBE] ==
        ($past(tx_febe_calc) ^ $past(ctrl_reg[CTL_FINV]));
  endproperty
  a_far_inv: assert property (p_far_inv) // [RULE3]
    else $error("v5 far error bit wrong");

  property p_rdi;
    tx_v5_slot && !ctrl_reg[CTL_AIS]
      |=> tx_byte_out[V5_RDI] == $past(ctrl_reg[CTL_RDI])
        && tx_byte_out[V5_RFI] == $past(ctrl_reg[CTL_RFI]);
  endproperty
  a_rdi: assert property (p_rdi) // [RULE4] [RULE5]
    else $error("v5 remote indication bits wrong");

  property p_obits;
    tx_obit2_slot && !tx_obit1_slot && !tx_v5_slot && !ctrl_reg[CTL_AIS]
      |=> tx_byte_out[5:2] == $past(obits_reg[7:4]);
  endproperty
  a_obits: assert property (p_obits) // [RULE7]
    else $error("second justification byte comm bits wrong");

  property p_no_trib;
    sel_reg[6:0] == 7'h00 && port_output_enable
      |=> drop_ais_gen && !trib_sel_valid;
  endproperty
  a_no_trib: assert property (p_no_trib) // [RULE9]
    else $error("no ais for unselected tributary");

  property p_oe_off;
    !port_output_enable |=> !line_out_oe && !drop_ais_gen;
  endproperty
  a_oe_off: assert property (p_oe_off) // [RULE11]
    else $error("disabled port still drives");

  property p_cnt_sat;
    cnt_reg[0] == CNT_MAX && !counter_reset && !rd_now && !rd_reg
      |=> cnt_reg[0] == CNT_MAX;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) // [RULE12]
    else $error("parity counter left saturation");

  property p_cnt_clr;
    counter_reset |=> cnt_reg[0] <= 8'h02 && cnt_reg[1] <= 8'h01;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) // [RULE14]
    else $error("counter not cleared");

  property p_ndf;
    rx_v1_strobe && rx_v1_byte[7:4] == NDF_CODE
      |=> lbl_alm_reg[ALM_NDF] ##1 (lbl_alm_reg[ALM_NDF] || $past(done_lbl));
  endproperty
  a_ndf: assert property (p_ndf) // [RULE18]
    else $error("new data flag not latched");

  property p_relatch;
    done_lbl && uneq_set |=> lbl_alm_reg[ALM_UNEQ];
  endproperty
  a_relatch: assert property (p_relatch) // [RULE16] [RULE22]
    else $error("active unequipped not relatched");
endmodule : vtoh_regs

// *** verification/vtoh_far_model.sv ***
// far-side drop bus framer model: rx overhead strobes and fifo events
// assumes the bench calls its tasks from the clk domain only
`timescale 1ns/1ns
module vtoh_far_model (
  input wire logic clk,
  output logic rx_v5_strobe,
  output logic [7:0] rx_v5_byte,
  output logic [1:0] rx_bip2_errs,
  output logic rx_v1_strobe,
  output logic [7:0] rx_v1_byte,
  output logic rx_ptr_frame,
  output logic rx_ptr_ais,
  output logic rx_ptr_bad,
  output logic add_fifo_ovf,
  output logic add_fifo_udf
);
  initial begin
    {rx_v5_strobe, rx_v1_strobe, rx_ptr_frame} = 3'h0;
    {rx_v5_byte, rx_v1_byte} = 16'h0000;
    {rx_bip2_errs, rx_ptr_ais, rx_ptr_bad} = 4'h0;
    {add_fifo_ovf, add_fifo_udf} = 2'h0;
  end

  // released data lines show the inverse so stale data never looks valid
  task automatic v5(input logic [7:0] b, input logic [1:0] e);
    @(posedge clk);
    rx_v5_strobe <= 1'b1;
    rx_v5_byte <= b;
    rx_bip2_errs <= e;
    @(posedge clk);
    rx_v5_strobe <= 1'b0;
    rx_v5_byte <= ~b;
    rx_bip2_errs <= ~e;
  endtask : v5

  task automatic v1(input logic [7:0] b);
    @(posedge clk);
    rx_v1_strobe <= 1'b1;
    rx_v1_byte <= b;
    @(posedge clk);
    rx_v1_strobe <= 1'b0;
    rx_v1_byte <= ~b;
  endtask : v1

  task automatic ptr(input logic a, input logic bad);
    @(posedge clk);
    rx_ptr_frame <= 1'b1;
    rx_ptr_ais <= a;
    rx_ptr_bad <= bad;
    @(posedge clk);
    rx_ptr_frame <= 1'b0;
    rx_ptr_ais <= ~a;
    rx_ptr_bad <= ~bad;
  endtask : ptr

  task automatic fifo(input logic o, input logic u);
    @(posedge clk);
    add_fifo_ovf <= o;
    add_fifo_udf <= u;
    @(posedge clk);
    add_fifo_ovf <= 1'b0;
    add_fifo_udf <= 1'b0;
  endtask : fifo
endmodule : vtoh_far_model

// *** verification/vtoh_regs_tb.sv ***
// self-checking bench for the tributary overhead register bank
// assumes the far-side model drives every rx strobe and fifo event
`timescale 1ns/1ns
module vtoh_regs_tb
  import vtoh_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n, cpu_cs_n, cpu_rd_n, cpu_wr_n, cpu_data_oe;
  logic [7:0] cpu_addr, cpu_data_in, cpu_data_out, tx_byte_in, tx_byte_out;
  logic port_output_enable, counter_reset, tx_febe_calc;
  logic tx_v5_slot, tx_obit1_slot, tx_obit2_slot, drop_bus_b_sel;
  logic [1:0] tx_bip2_calc, trib_sts, trib_vt, rx_bip2_errs;
  logic [2:0] trib_grp;
  logic trib_sel_valid, drop_ais_gen, line_out_oe, add_fifo_reset;
  logic rx_v5_strobe, rx_v1_strobe, rx_ptr_frame, rx_ptr_ais, rx_ptr_bad;
  logic [7:0] rx_v5_byte, rx_v1_byte, d;
  logic add_fifo_ovf, add_fifo_udf;
  int n_mismatch = 0;
  int checks_done = 0;

  always #25 clk = ~clk;

  vtoh_regs dut_u (.clk(clk), .rst_n(rst_n), .cpu_addr(cpu_addr),
    .cpu_data_in(cpu_data_in), .cpu_data_out(cpu_data_out),
    .cpu_data_oe(cpu_data_oe), .cpu_cs_n(cpu_cs_n), .cpu_rd_n(cpu_rd_n),
    .cpu_wr_n(cpu_wr_n), .port_output_enable(port_output_enable),
    .counter_reset(counter_reset), .tx_byte_in(tx_byte_in),
    .tx_v5_slot(tx_v5_slot), .tx_obit1_slot(tx_obit1_slot),
    .tx_obit2_slot(tx_obit2_slot), .tx_bip2_calc(tx_bip2_calc),
    .tx_febe_calc(tx_febe_calc), .tx_byte_out(tx_byte_out),
    .drop_bus_b_sel(drop_bus_b_sel), .trib_sel_valid(trib_sel_valid),
    .trib_sts(trib_sts), .trib_grp(trib_grp), .trib_vt(trib_vt),
    .drop_ais_gen(drop_ais_gen), .line_out_oe(line_out_oe),
    .rx_v5_strobe(rx_v5_strobe), .rx_v5_byte(rx_v5_byte),
    .rx_bip2_errs(rx_bip2_errs), .rx_v1_strobe(rx_v1_strobe),
    .rx_v1_byte(rx_v1_byte), .rx_ptr_frame(rx_ptr_frame),
    .rx_ptr_ais(rx_ptr_ais), .rx_ptr_bad(rx_ptr_bad),
    .add_fifo_ovf(add_fifo_ovf), .add_fifo_udf(add_fifo_udf),
    .add_fifo_reset(add_fifo_reset));

  vtoh_far_model far_u (.clk(clk), .rx_v5_strobe(rx_v5_strobe),
    .rx_v5_byte(rx_v5_byte), .rx_bip2_errs(rx_bip2_errs),
    .rx_v1_strobe(rx_v1_strobe), .rx_v1_byte(rx_v1_byte),
    .rx_ptr_frame(rx_ptr_frame), .rx_ptr_ais(rx_ptr_ais),
    .rx_ptr_bad(rx_ptr_bad), .add_fifo_ovf(add_fifo_ovf),
    .add_fifo_udf(add_fifo_udf));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    cpu_cs_n <= 1'b0;
    cpu_wr_n <= 1'b0;
    cpu_addr <= a;
    cpu_data_in <= v;
    repeat (2) @(posedge clk);
    cpu_cs_n <= 1'b1;
    cpu_wr_n <= 1'b1;
    cpu_data_in <= ~v;
    @(posedge clk);
  endtask : wr

  // inj puts one parity error on the rx side while the strobe is held
  task automatic rd(input logic [7:0] a, input bit inj);
    @(posedge clk);
    cpu_cs_n <= 1'b0;
    cpu_rd_n <= 1'b0;
    cpu_addr <= a;
    @(posedge clk);
    if (inj) far_u.v5(8'h00, 2'h1);
    @(posedge clk);
    #1;
    d = cpu_data_out;
    chk("read enable", 8'h01, {7'h00, cpu_data_oe});
    @(posedge clk);
    cpu_cs_n <= 1'b1;
    cpu_rd_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : rd

  task automatic rdchk(input string nm, input logic [7:0] a, e);
    rd(a, 1'b0);
    chk(nm, e, d);
  endtask : rdchk

  task automatic txb(input logic [2:0] s, input logic [7:0] b, e);
    @(posedge clk);
    {tx_v5_slot, tx_obit1_slot, tx_obit2_slot} <= s;
    tx_byte_in <= b;
    @(posedge clk);
    #1;
    chk("tx byte", e, tx_byte_out);
    @(posedge clk);
    {tx_v5_slot, tx_obit1_slot, tx_obit2_slot} <= 3'h0;
  endtask : txb

  task automatic t_regs;
    for (int i = 0; i < 10; i++) rdchk("reset", 8'(8'h2d + i), REG_RESET);
    wr(ADDR_EXP_LBL, 8'hff);
    rdchk("expected label", ADDR_EXP_LBL, 8'h07);
    wr(ADDR_PAR_CNT, 8'h55);
    rdchk("count write", ADDR_PAR_CNT, 8'h00);
    wr(8'h40, 8'h66);
    rdchk("unmapped", 8'h40, 8'h00);
    wr(ADDR_TX_OBITS, 8'ha5);
    rdchk("comm bits", ADDR_TX_OBITS, 8'ha5);
    $display("test regs done");
  endtask : t_regs

  task automatic t_tx;
    wr(ADDR_TX_CTRL, 8'h00);
    txb(3'b100, 8'h00, 8'h80);
    wr(ADDR_TX_CTRL, 8'h7e);
    txb(3'b100, 8'h00, 8'h77);
    wr(ADDR_TX_CTRL, 8'h50);
    txb(3'b100, 8'h00, 8'h41);
    wr(ADDR_TX_CTRL, 8'h28);
    txb(3'b100, 8'h00, 8'hb0);
    tx_febe_calc <= 1'b1;
    txb(3'b100, 8'h00, 8'h90);
    tx_febe_calc <= 1'b0;
    txb(3'b010, 8'hc3, 8'hd7);
    txb(3'b001, 8'h00, 8'h28);
    wr(ADDR_TX_CTRL, 8'h80);
    txb(3'b100, 8'h00, 8'hff);
    txb(3'b000, 8'h12, 8'hff);
    wr(ADDR_TX_CTRL, 8'h00);
    txb(3'b000, 8'h12, 8'h12);
    $display("test transmit done");
  endtask : t_tx

  task automatic t_drop;
    logic [7:0] code [3] = '{8'h81, 8'h1d, 8'hb9};
    logic [7:0] bad [3] = '{8'h00, 8'h55, 8'h7f};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_DROP_SEL, code[i]);
      repeat (2) @(posedge clk);
      #1;
      chk("decode", {1'b1, 2'(i), 5'h00},
        {trib_sel_valid, trib_sts, trib_grp, trib_vt});
      chk("side", {6'h00, code[i][7], 1'b0},
        {6'h00, drop_bus_b_sel, drop_ais_gen});
    end
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_DROP_SEL, bad[i]);
      repeat (2) @(posedge clk);
      #1;
      chk("no trib", 8'h01, {6'h00, trib_sel_valid, drop_ais_gen});
    end
    @(posedge clk);
    port_output_enable <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("tristate", 8'h00, {6'h00, line_out_oe, drop_ais_gen});
    @(posedge clk);
    port_output_enable <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("enabled", 8'h03, {6'h00, line_out_oe, drop_ais_gen});
    $display("test drop select done");
  endtask : t_drop

  task automatic t_count;
    repeat (3) far_u.v5(8'h20, 2'h2);
    rdchk("parity", ADDR_PAR_CNT, 8'h06);
    rdchk("parity", ADDR_PAR_CNT, 8'h00);
    rdchk("far err", ADDR_FAR_CNT, 8'h03);
    rd(ADDR_PAR_CNT, 1'b1);
    chk("parity", 8'h00, d);
    rdchk("held error", ADDR_PAR_CNT, 8'h01);
    repeat (2) far_u.v5(8'h20, 2'h1);
    @(posedge clk);
    counter_reset <= 1'b1;
    @(posedge clk);
    counter_reset <= 1'b0;
    rdchk("cleared", ADDR_PAR_CNT, 8'h00);
    rdchk("cleared", ADDR_FAR_CNT, 8'h00);
    repeat (260) far_u.v5(8'h20, 2'h2);
    rdchk("saturate", ADDR_PAR_CNT, CNT_MAX);
    rdchk("saturate", ADDR_FAR_CNT, CNT_MAX);
    $display("test counters done");
  endtask : t_count

  task automatic t_alarm;
    wr(ADDR_EXP_LBL, 8'h05);
    far_u.v5(8'h00, 2'h0);
    rdchk("label", ADDR_LBL_ALM, 8'hc0);
    rdchk("relatch", ADDR_LBL_ALM, 8'hc0);
    far_u.v5(8'h0c, 2'h0);
    rdchk("mismatch", ADDR_LBL_ALM, 8'hc0);
    far_u.v5(8'h0a, 2'h0);
    rdchk("latched", ADDR_LBL_ALM, 8'h40);
    rdchk("clear", ADDR_LBL_ALM, 8'h00);
    far_u.v1(8'h90);
    far_u.fifo(1'b1, 1'b0);
    #1;
    chk("fifo reset", 8'h01, {7'h00, add_fifo_reset});
    rdchk("v1 alarms", ADDR_LBL_ALM, 8'h09);
    rdchk("size", ADDR_PTR_ALM, 8'h20);
    far_u.fifo(1'b0, 1'b1);
    #1;
    chk("fifo reset", 8'h01, {7'h00, add_fifo_reset});
    rdchk("underflow", ADDR_LBL_ALM, 8'h01);
    rdchk("clear", ADDR_LBL_ALM, 8'h00);
    repeat (2) far_u.ptr(1'b1, 1'b0);
    far_u.ptr(1'b0, 1'b0);
    rdchk("short ais", ADDR_PTR_ALM, 8'h00);
    repeat (3) far_u.ptr(1'b1, 1'b0);
    rdchk("ais", ADDR_PTR_ALM, 8'h80);
    far_u.ptr(1'b0, 1'b0);
    rdchk("ais latched", ADDR_PTR_ALM, 8'h80);
    rdchk("ais clear", ADDR_PTR_ALM, 8'h00);
    repeat (7) far_u.ptr(1'b0, 1'b1);
    far_u.ptr(1'b0, 1'b0);
    rdchk("short lop", ADDR_PTR_ALM, 8'h00);
    repeat (8) far_u.ptr(1'b0, 1'b1);
    rdchk("lop", ADDR_PTR_ALM, 8'h40);
    rdchk("lop relatch", ADDR_PTR_ALM, 8'h40);
    $display("test alarms done");
  endtask : t_alarm

  initial begin
    rst_n = 1'b0;
    {cpu_cs_n, cpu_rd_n, cpu_wr_n} = 3'h7;
    {cpu_addr, cpu_data_in, tx_byte_in} = 24'h00_0000;
    {port_output_enable, counter_reset} = 2'h2;
    {tx_v5_slot, tx_obit1_slot, tx_obit2_slot, tx_febe_calc} = 4'h0;
    tx_bip2_calc = 2'h2;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_tx();
    t_drop();
    t_count();
    t_alarm();
    end_of_test();
  end

  // the run needs about 950 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("BAD watchdog expected done seen hang");
    end_of_test();
  end
endmodule : vtoh_regs_tb
